/* rtl/cfl_flags_irq.sv */
// Condition flags, interrupt entry and low-supply detector control
// Overview of operation
// - Five condition flags, each readable for branch and test instructions.
// - Half-carry set on carry from bit 3 into 4 during add and add-with-carry.
// - Mask flag at one blocks every maskable interrupt; clearing it reopens them.
// - Masked wake-up and timer requests latch, one per source, and are serviced once unmasked; the low-supply request is not latched.
// - Negative flag copies the result's top bit.
// - Zero flag set when the result is zero, cleared otherwise.
// - Carry records carry or borrow; bit-test, branch, shift and rotate update it.
// - Vectors at top: reset 3FFE, trap 3FFC, timer 3FF8, two bytes each.
// - Wake from halt goes to the wake-up vector despite a low-supply request.
// - Unmasking inside the wake-up handler lets a low-supply request enter at once.
// - Low supply with detector on sets the flag; request raised when enabled.
// - Flag and request follow the detector; the flag bit cannot be written, and clearing the enable drops both.
// - Detector enable at zero powers it off and forces the flag low.
// - Flag undefined for 5 us after enabling; it is ignored during that time.
// - Halt switches the detector off and holds the flag at zero.
// - Wait leaves the detector, flag and request running as in run mode.
// - Enable, detector on and flag sit at bits 4, 3 and 2 of misc control.
// - Entry pushes PC, X, A and flags and sets the mask; Y is not saved.
`timescale 1ns/1ps
module cfl_flags_irq #(
	parameter int SU_CYCLES = cfl_pkg::STARTUP_CY
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 resetn,
	// Execution unit flag traffic
	input  cfl_pkg::cfl_alu_t         alu,
	input  wire logic                 cf_load,
	input  wire logic [4:0]           cf_load_val,
	input  wire logic                 mask_set,
	input  wire logic                 unmask_instruction,
	input  wire logic                 int_check,
	input  wire logic                 trap_req,
	// Power modes
	input  wire logic                 halt_mode,
	input  wire logic                 wait_mode,
	// Interrupt sources
	input  wire logic                 wakeup_pin,
	input  wire logic                 timer_event_flags,
	input  wire logic                 low_supply_detector,
	// Register port
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	output logic [7:0]                reg_rdata,
	// Flags and entry
	output logic [4:0]                condition_flags,
	output cfl_pkg::cfl_entry_t       entry,
	// Low supply
	output logic                      low_supply_detector_on,
	output logic                      low_supply_flag,
	output logic                      low_supply_irq,
	// Other control bits
	output logic                      ram0_map,
	output logic                      ram1_map,
	output logic                      wakeup_level_opt,
	output logic                      wakeup_disable
);

	////////////////////////////////////////////////////////////////
	// Block state, one packed image
	// Pending latches exist only for sources that pulse; the low-supply request
	// is a level from the detector and is never latched, so it vanishes with the
	// low condition even if the core never got round to servicing it.
	typedef struct packed {
		logic [4:0]          cf;
		logic                ram0;
		logic                ram1;
		logic                lie;
		logic                lon;
		logic                into;
		logic                into_lock;
		logic                wfd;
		logic                trap_pend;
		logic                wake_pend;
		logic                tmr_pend;
		logic [cfl_pkg::SU_W-1:0] su_cnt;
		logic                su_done;
		logic                lsf;
		logic                lirq;
		logic                halt_q;
		logic                wait_q;
		cfl_pkg::cfl_entry_t ent;
		logic [7:0]          rdata;
	} cfl_state_t;

	cfl_state_t        st_r;
	cfl_state_t        st_nxt;
	logic              det_sync;
	logic              det_active;
	cfl_pkg::cfl_src_t arb_src;
	logic [13:0]       arb_vec;
	logic [7:0]        misc_view;

	// Last count of the start-up window; the counter stops once it is reached,
	// so it cannot wrap and reopen the window during a long run.
	localparam logic [cfl_pkg::SU_W-1:0] SU_LAST = cfl_pkg::SU_W'(SU_CYCLES - 1);

	////////////////////////////////////////////////////////////////
	// Detector output synchroniser
	// The comparator has no relation to clk; only the second stage is read,
	// so a metastable first stage never reaches the flag or the request.
	cfl_sync2 u_det_sync (
		.clk     (clk),
		.resetn  (resetn),
		.d_async (low_supply_detector),
		.q       (det_sync)
	);

	// Priority and vector of the highest pending source
	// The arbiter is pure logic on registered latches; its choice is registered below
	cfl_irq_arb u_arb (
		.trap   (st_r.trap_pend),
		.wake   (st_r.wake_pend),
		.timer  (st_r.tmr_pend),
		.lowsup (st_r.lirq),
		.mask   (st_r.cf[cfl_pkg::CF_I]),
		.src    (arb_src),
		.vec    (arb_vec)
	);

	// Detector powered only when enabled and not halted; wait is no factor
	// Halt is taken from the pin level, not a registered copy, so the flag
	// drops on the first edge of halt and never one edge late.
	assign det_active = st_r.lon && !halt_mode;

	// Register view; bit 5 is unused and reads zero
	always_comb begin
		misc_view                   = '0;
		misc_view[cfl_pkg::MB_RAM0] = st_r.ram0;
		misc_view[cfl_pkg::MB_RAM1] = st_r.ram1;
		misc_view[cfl_pkg::MB_LIE]  = st_r.lie;
		misc_view[cfl_pkg::MB_LON]  = st_r.lon;
		misc_view[cfl_pkg::MB_LFL]  = st_r.lsf;
		misc_view[cfl_pkg::MB_INTO] = st_r.into;
		misc_view[cfl_pkg::MB_WFD]  = st_r.wfd;
	end

	////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		st_nxt          = st_r;
		st_nxt.ent.take = 1'b0;
		st_nxt.halt_q   = halt_mode;
		st_nxt.wait_q   = wait_mode;

		// Flag updates by operation kind
		unique case (alu.op)
			cfl_pkg::OP_ADD, cfl_pkg::OP_ADC: begin
				st_nxt.cf[cfl_pkg::CF_H] = alu.c3;
				st_nxt.cf[cfl_pkg::CF_N] = alu.res[7];
				st_nxt.cf[cfl_pkg::CF_Z] = (alu.res == 8'h00);
				st_nxt.cf[cfl_pkg::CF_C] = alu.c_out;
			end
			cfl_pkg::OP_SUB, cfl_pkg::OP_SHIFT: begin
				st_nxt.cf[cfl_pkg::CF_N] = alu.res[7];
				st_nxt.cf[cfl_pkg::CF_Z] = (alu.res == 8'h00);
				st_nxt.cf[cfl_pkg::CF_C] = alu.c_out;
			end
			cfl_pkg::OP_LOGIC, cfl_pkg::OP_MOVE: begin
				st_nxt.cf[cfl_pkg::CF_N] = alu.res[7];
				st_nxt.cf[cfl_pkg::CF_Z] = (alu.res == 8'h00);
			end
			cfl_pkg::OP_BITTEST: begin
				// Bit test and bit-test-branch copy the tested bit
				st_nxt.cf[cfl_pkg::CF_C] = alu.c_out;
			end
			cfl_pkg::OP_NONE: begin
			end
			default: begin
			end
		endcase

		// Whole-register load, used on return and pop; beats an ALU update
		if (cf_load) begin
			st_nxt.cf = cf_load_val;
		end

		// Explicit mask instructions
		if (mask_set) begin
			st_nxt.cf[cfl_pkg::CF_I] = 1'b1;
		end else if (unmask_instruction) begin
			st_nxt.cf[cfl_pkg::CF_I] = 1'b0;
		end

		// Entering wait or halt reopens interrupts so a source can wake the core
		if ((halt_mode && !st_r.halt_q) || (wait_mode && !st_r.wait_q)) begin
			st_nxt.cf[cfl_pkg::CF_I] = 1'b0;
		end

		// Interrupt entry at an instruction boundary
		// Flags to push are the image before this edge, so the mask that the
		// entry itself sets never appears in the saved copy.
		if (int_check && arb_src != cfl_pkg::SRC_NONE) begin
			st_nxt.ent.take     = 1'b1;
			st_nxt.ent.src      = arb_src;
			st_nxt.ent.vec      = arb_vec;
			st_nxt.ent.saved_cf = st_r.cf;
			st_nxt.cf[cfl_pkg::CF_I] = 1'b1;
			unique case (arb_src)
				cfl_pkg::SRC_TRAP:  st_nxt.trap_pend = 1'b0;
				cfl_pkg::SRC_WAKE:  st_nxt.wake_pend = 1'b0;
				cfl_pkg::SRC_TIMER: st_nxt.tmr_pend  = 1'b0;
				default: begin
				end
			endcase
		end

		// Request latches: one per source, a new event beats the service clear
		// A request raised in the cycle of its own service must not be lost,
		// so the set is applied after the clear.
		if (trap_req) begin
			st_nxt.trap_pend = 1'b1;
		end
		if (wakeup_pin) begin
			st_nxt.wake_pend = 1'b1;
		end
		if (timer_event_flags) begin
			st_nxt.tmr_pend = 1'b1;
		end

		// Start-up window: the flag is ignored until the detector settles
		if (!det_active) begin
			st_nxt.su_cnt  = '0;
			st_nxt.su_done = 1'b0;
		end else if (!st_r.su_done) begin
			st_nxt.su_cnt  = st_r.su_cnt + 1'b1;
			st_nxt.su_done = (st_r.su_cnt == SU_LAST);
		end

		// Flag and request track the detector, not latched
		st_nxt.lsf  = det_active && st_r.su_done && det_sync;
		st_nxt.lirq = det_active && st_r.su_done && det_sync && st_r.lie;

		// Register write; flag bit is read-only
		// Clearing the enable must drop the flag at once, even though the
		// synchronised detector may still report low for two more clocks.
		if (reg_wr && reg_addr == cfl_pkg::MISC_ADDR) begin
			st_nxt.ram0 = reg_wdata[cfl_pkg::MB_RAM0];
			st_nxt.ram1 = reg_wdata[cfl_pkg::MB_RAM1];
			st_nxt.lie  = reg_wdata[cfl_pkg::MB_LIE];
			st_nxt.lon  = reg_wdata[cfl_pkg::MB_LON];
			st_nxt.wfd  = reg_wdata[cfl_pkg::MB_WFD];
			// Option bit accepts only the first write after reset
			if (!st_r.into_lock) begin
				st_nxt.into      = reg_wdata[cfl_pkg::MB_INTO];
				st_nxt.into_lock = 1'b1;
			end
			// Clearing the enable drops the flag on the next edge
			if (!reg_wdata[cfl_pkg::MB_LON]) begin
				st_nxt.lsf  = 1'b0;
				st_nxt.lirq = 1'b0;
			end
		end

		// Register read, zero for other addresses
		st_nxt.rdata = 8'h00;
		if (reg_rd && reg_addr == cfl_pkg::MISC_ADDR) begin
			st_nxt.rdata = misc_view;
		end
	end

	////////////////////////////////////////////////////////////////
	// State register with its reset image
	// Reset loads constants only: the mask set, the reset vector selected
	// and the option bit at its reset default.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r              <= '0;
			st_r.cf           <= cfl_pkg::CF_RST;
			st_r.ram0         <= cfl_pkg::MISC_RST[cfl_pkg::MB_RAM0];
			st_r.ram1         <= cfl_pkg::MISC_RST[cfl_pkg::MB_RAM1];
			st_r.lie          <= cfl_pkg::MISC_RST[cfl_pkg::MB_LIE];
			st_r.lon          <= cfl_pkg::MISC_RST[cfl_pkg::MB_LON];
			st_r.into         <= cfl_pkg::MISC_RST[cfl_pkg::MB_INTO];
			st_r.wfd          <= cfl_pkg::MISC_RST[cfl_pkg::MB_WFD];
			st_r.ent.src      <= cfl_pkg::SRC_NONE;
			st_r.ent.vec      <= cfl_pkg::VEC_RESET;
			st_r.ent.saved_cf <= cfl_pkg::CF_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register
	// No output passes through logic after the register, so timing into the
	// core starts at a clean clock-to-q.
	assign reg_rdata              = st_r.rdata;
	assign condition_flags        = st_r.cf;
	assign entry                  = st_r.ent;
	assign low_supply_detector_on = st_r.lon;
	assign low_supply_flag        = st_r.lsf;
	assign low_supply_irq         = st_r.lirq;
	assign ram0_map               = st_r.ram0;
	assign ram1_map               = st_r.ram1;
	assign wakeup_level_opt       = st_r.into;
	assign wakeup_disable         = st_r.wfd;

endmodule : cfl_flags_irq

/* rtl/cfl_irq_arb.sv */
// Interrupt priority selection and vector lookup
`timescale 1ns/1ps
module cfl_irq_arb (
	// Requests
	input  wire logic    trap,
	input  wire logic    wake,
	input  wire logic    timer,
	input  wire logic    lowsup,
	input  wire logic    mask,
	// Selection
	output cfl_pkg::cfl_src_t src,
	output logic [13:0]  vec
);

	////////////////////////////////////////////////////////////////
	// Trap ignores the mask; wake-up outranks the low-supply source
	always_comb begin
		src = cfl_pkg::SRC_NONE;
		vec = cfl_pkg::VEC_RESET;
		if (trap) begin
			src = cfl_pkg::SRC_TRAP;
			vec = cfl_pkg::VEC_TRAP;
		end else if (!mask && wake) begin
			src = cfl_pkg::SRC_WAKE;
			vec = cfl_pkg::VEC_WAKE;
		end else if (!mask && timer) begin
			src = cfl_pkg::SRC_TIMER;
			vec = cfl_pkg::VEC_TIMER;
		end else if (!mask && lowsup) begin
			src = cfl_pkg::SRC_LOWSUP;
			vec = cfl_pkg::VEC_LOWSUP;
		end
	end

endmodule : cfl_irq_arb

/* rtl/cfl_pkg.sv */
// Constants and carrier types for the condition-flag and interrupt-entry block
package cfl_pkg;

	// Condition flag layout
	localparam int              CF_W   = 5;
	localparam int              CF_H   = 4;
	localparam int              CF_I   = 3;
	localparam int              CF_N   = 2;
	localparam int              CF_Z   = 1;
	localparam int              CF_C   = 0;
	localparam logic [CF_W-1:0] CF_RST = 5'h08; // Only the mask set

	// Miscellaneous control register
	localparam logic [7:0] MISC_ADDR = 8'h08;
	localparam logic [7:0] MISC_RST  = 8'h02;
	localparam int         MB_RAM0   = 7;
	localparam int         MB_RAM1   = 6;
	localparam int         MB_LIE    = 4;
	localparam int         MB_LON    = 3;
	localparam int         MB_LFL    = 2;
	localparam int         MB_INTO   = 1;
	localparam int         MB_WFD    = 0;

	// Vector addresses, low byte of each two-byte pair
	localparam int          VEC_W      = 14;
	localparam logic [13:0] VEC_RESET  = 14'h3FFE;
	localparam logic [13:0] VEC_TRAP   = 14'h3FFC;
	localparam logic [13:0] VEC_WAKE   = 14'h3FFA;
	localparam logic [13:0] VEC_TIMER  = 14'h3FF8;
	localparam logic [13:0] VEC_LOWSUP = 14'h3FF6;

	// Detector start-up time, rounded up to whole clocks
	localparam int CLK_NS     = 4;
	localparam int STARTUP_NS = 5000;
	localparam int STARTUP_CY = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int SU_W       = 11;

	// Kind of operation that updates the flags
	typedef enum logic [2:0] {
		OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_LOGIC, OP_MOVE, OP_BITTEST, OP_SHIFT
	} cfl_op_t;

	// Flag update from the execution unit
	typedef struct packed {
		cfl_op_t    op;
		logic [7:0] res;   // Result byte
		logic       c_out; // Carry/borrow out, tested bit, or shifted-out bit
		logic       c3;    // Carry from bit 3 into bit 4
	} cfl_alu_t;

	// Interrupt sources
	typedef enum logic [2:0] {
		SRC_NONE, SRC_TRAP, SRC_WAKE, SRC_TIMER, SRC_LOWSUP
	} cfl_src_t;

	// Interrupt entry towards the execution unit
	typedef struct packed {
		logic            take;     // One-cycle entry pulse
		cfl_src_t        src;
		logic [13:0]     vec;
		logic [CF_W-1:0] saved_cf; // Flags to push, before the mask is set
	} cfl_entry_t;

	// Two-stage synchroniser state
	typedef struct packed {
		logic s1;
		logic s2;
	} cfl_sync_t;

endpackage : cfl_pkg

/* rtl/cfl_sync2.sv */
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
module cfl_sync2 (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Level
	input  wire logic d_async,
	output logic      q
);

	cfl_pkg::cfl_sync_t st_r;
	cfl_pkg::cfl_sync_t st_nxt;

	////////////////////////////////////////////////////////////////
	// First stage feeds only the second
	always_comb begin
		st_nxt.s1 = d_async;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.s2;

endmodule : cfl_sync2

/* tb/cfl_flags_irq_sva.sv */
// Assertion checker for the condition-flag and interrupt-entry block
`timescale 1ns/1ps
module cfl_flags_irq_sva (
	// Clock and reset
	input wire logic           clk,
	input wire logic           resetn,
	// Watched inputs
	input cfl_pkg::cfl_alu_t   alu,
	input wire logic           cf_load,
	input wire logic           halt_mode,
	input wire logic           low_supply_detector,
	// Watched outputs
	input wire logic [4:0]     condition_flags,
	input cfl_pkg::cfl_entry_t entry,
	input wire logic           low_supply_detector_on,
	input wire logic           low_supply_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	////////////////////////////////////////////////////////////////
	// A whole-register load overrides any ALU update
	logic upd;
	assign upd = alu.op != cfl_pkg::OP_NONE && !cf_load;

	// Entry is one step of a longer walk, so name it once
	sequence s_take;
		entry.take;
	endsequence

	chk_half_carry: assert property (
		upd && alu.op inside {cfl_pkg::OP_ADD, cfl_pkg::OP_ADC} |=> condition_flags[4] == $past(alu.c3))
		else $error("half carry not taken from bit 3");
	chk_neg_zero: assert property (
		upd && alu.op != cfl_pkg::OP_BITTEST |=> condition_flags[2] == $past(alu.res[7])
		&& condition_flags[1] == ($past(alu.res) == 8'h00))
		else $error("negative or zero flag wrong");
	chk_carry_out: assert property (
		upd && !(alu.op inside {cfl_pkg::OP_LOGIC, cfl_pkg::OP_MOVE}) |=> condition_flags[0] == $past(alu.c_out))
		else $error("carry flag wrong");
	chk_mask_gate: assert property (
		s_take |-> entry.src == cfl_pkg::SRC_TRAP || !$past(condition_flags[3]))
		else $error("maskable entry while masked");
	chk_vector_map: assert property (
		s_take |-> entry.vec == (entry.src == cfl_pkg::SRC_TRAP ? 14'h3FFC : entry.src == cfl_pkg::SRC_WAKE ?
		14'h3FFA : entry.src == cfl_pkg::SRC_TIMER ? 14'h3FF8 : 14'h3FF6) && entry.src != cfl_pkg::SRC_NONE)
		else $error("vector does not match source");
	chk_entry_save: assert property (
		s_take |-> condition_flags[3] && entry.saved_cf == $past(condition_flags))
		else $error("entry did not save flags or set mask");
	chk_lsup_off: assert property (
		!low_supply_detector_on |=> !low_supply_flag)
		else $error("flag high with detector off");
	chk_halt_hold: assert property (
		halt_mode ##1 halt_mode |-> !low_supply_flag)
		else $error("flag high in halt");
	chk_sync_path: assert property (
		$rose(low_supply_flag) |-> $past(low_supply_detector, 3))
		else $error("flag rose without synchronised detector");
endmodule : cfl_flags_irq_sva

bind cfl_flags_irq cfl_flags_irq_sva chk_u (.clk(clk), .resetn(resetn), .alu(alu), .cf_load(cf_load),
	.halt_mode(halt_mode), .low_supply_detector(low_supply_detector), .condition_flags(condition_flags),
	.entry(entry), .low_supply_detector_on(low_supply_detector_on), .low_supply_flag(low_supply_flag));

/* tb/cfl_flags_irq_tb_top.sv */
// Self-checking bench for the condition-flag and interrupt-entry block
`timescale 1ns/1ps
module cfl_flags_irq_tb_top;
	logic                clk, resetn, cf_load, mask_set, unmask_instruction, int_check, trap_req;
	logic                halt_mode, wait_mode, wakeup_pin, timer_event_flags, det, supply_low;
	logic                reg_wr, reg_rd, lon, flag, irq, opt, ram0, ram1, wfd;
	logic [7:0]          reg_addr, reg_wdata, reg_rdata;
	logic [4:0]          cf_load_val, condition_flags;
	cfl_pkg::cfl_alu_t   alu;
	cfl_pkg::cfl_entry_t entry;
	int                  err_count, check_count;

	////////////////////////////////////////////////////////////////
	// Short start-up count keeps the run brief
	cfl_flags_irq #(.SU_CYCLES(4)) dut_u (.clk(clk), .resetn(resetn), .alu(alu), .cf_load(cf_load),
		.cf_load_val(cf_load_val), .mask_set(mask_set), .unmask_instruction(unmask_instruction),
		.int_check(int_check), .trap_req(trap_req), .halt_mode(halt_mode), .wait_mode(wait_mode),
		.wakeup_pin(wakeup_pin), .timer_event_flags(timer_event_flags), .low_supply_detector(det),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.condition_flags(condition_flags), .entry(entry), .low_supply_detector_on(lon),
		.low_supply_flag(flag), .low_supply_irq(irq), .ram0_map(ram0), .ram1_map(ram1), .wakeup_level_opt(opt),
		.wakeup_disable(wfd));
	// Comparator junk ends well inside the design's start-up count
	cfl_supply_model #(.SU_STEPS(4)) sup_u (.supply_low(supply_low), .detector_on(lon), .halt_mode(halt_mode),
		.detector_out(det));

	// Free-running 250 MHz clock
	always #2 clk = ~clk;

	////////////////////////////////////////////////////////////////
	// Shared helpers; inputs move only at the falling edge
	task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : cmp

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse

	task automatic wr(input logic [7:0] d);
		reg_addr = cfl_pkg::MISC_ADDR;
		reg_wdata = d;
		pulse(reg_wr);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		pulse(reg_rd);
		cmp("reg_rdata", exp, reg_rdata);
	endtask : rd

	task automatic alu_chk(input cfl_pkg::cfl_op_t op, input logic [7:0] res, input logic c, input logic h,
		input logic [4:0] exp);
		alu = '{op, res, c, h};
		tick(1);
		cmp("condition_flags", exp, condition_flags);
	endtask : alu_chk

	// Entry shows in the cycle after the boundary pulse
	task automatic irq_chk(input cfl_pkg::cfl_src_t s, input logic [13:0] v);
		pulse(int_check);
		cmp("take", s != cfl_pkg::SRC_NONE, entry.take);
		if (s != cfl_pkg::SRC_NONE) begin
			cmp("src", s, entry.src);
			cmp("vec", v, entry.vec);
			cmp("mask", 1'b1, condition_flags[3]);
		end
	endtask : irq_chk

	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		cmp("condition_flags", 5'h08, condition_flags);
		cmp("vec", 14'h3FFE, entry.vec);
		resetn = 1'b1;
		tick(1);
		rd(8'h08, 8'h02);
	endtask : t_reset

	task automatic t_alu;
		alu_chk(cfl_pkg::OP_ADD, 8'h00, 1'b1, 1'b1, 5'h1B);
		alu_chk(cfl_pkg::OP_ADC, 8'h80, 1'b0, 1'b0, 5'h0C);
		alu_chk(cfl_pkg::OP_SUB, 8'h01, 1'b1, 1'b1, 5'h09);
		alu_chk(cfl_pkg::OP_LOGIC, 8'h00, 1'b0, 1'b1, 5'h0B);
		alu_chk(cfl_pkg::OP_MOVE, 8'hFF, 1'b0, 1'b1, 5'h0D);
		alu_chk(cfl_pkg::OP_BITTEST, 8'h00, 1'b0, 1'b1, 5'h0C);
		alu_chk(cfl_pkg::OP_SHIFT, 8'h40, 1'b1, 1'b1, 5'h09);
		cf_load_val = 5'h1D;
		cf_load = 1'b1;
		alu_chk(cfl_pkg::OP_ADD, 8'h00, 1'b0, 1'b0, 5'h1D);
		cf_load = 1'b0;
		alu.op = cfl_pkg::OP_NONE;
	endtask : t_alu

	task automatic t_irq;
		pulse(unmask_instruction);
		pulse(mask_set);
		pulse(wakeup_pin);
		irq_chk(cfl_pkg::SRC_NONE, 14'h0000);
		pulse(unmask_instruction);
		irq_chk(cfl_pkg::SRC_WAKE, 14'h3FFA);
		pulse(timer_event_flags);
		tick(1);
		pulse(timer_event_flags);
		pulse(unmask_instruction);
		irq_chk(cfl_pkg::SRC_TIMER, 14'h3FF8);
		pulse(unmask_instruction);
		irq_chk(cfl_pkg::SRC_NONE, 14'h0000);
		pulse(mask_set);
		pulse(trap_req);
		irq_chk(cfl_pkg::SRC_TRAP, 14'h3FFC);
	endtask : t_irq

	// Waits exceed start-up plus synchroniser, so an unsettled flag is never judged
	task automatic t_low;
		supply_low = 1'b1;
		wr(8'h18);
		tick(30);
		cmp("flag", 1'b1, flag);
		cmp("irq", 1'b1, irq);
		cmp("opt", 1'b0, opt);
		cmp("lon", 1'b1, lon);
		wr(8'h1A);
		tick(2);
		cmp("flag", 1'b1, flag);
		rd(8'h08, 8'h1C);
		tick(1);
		rd(8'h05, 8'h00);
		wait_mode = 1'b1;
		tick(10);
		cmp("irq", 1'b1, irq);
		supply_low = 1'b0;
		tick(10);
		cmp("flag", 1'b0, flag);
		supply_low = 1'b1;
		wait_mode = 1'b0;
		halt_mode = 1'b1;
		tick(10);
		cmp("flag", 1'b0, flag);
		pulse(wakeup_pin);
		halt_mode = 1'b0;
		tick(30);
		cmp("irq", 1'b1, irq);
		irq_chk(cfl_pkg::SRC_WAKE, 14'h3FFA);
		pulse(unmask_instruction);
		irq_chk(cfl_pkg::SRC_LOWSUP, 14'h3FF6);
		wr(8'h10);
		tick(2);
		cmp("flag", 1'b0, flag);
		cmp("irq", 1'b0, irq);
		wr(8'hC3);
		tick(2);
		cmp("ram0_map", 1'b1, ram0);
		cmp("ram1_map", 1'b1, ram1);
		cmp("wakeup_disable", 1'b1, wfd);
		cmp("opt", 1'b0, opt);
		cmp("lon", 1'b0, lon);
		rd(8'h08, 8'hC1);
	endtask : t_low

	task automatic finish_test;
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	////////////////////////////////////////////////////////////////
	// Main sequence: reset held for 8 cycles
	initial begin
		{clk, resetn, cf_load, mask_set, unmask_instruction, int_check, trap_req} = '0;
		{halt_mode, wait_mode, wakeup_pin, timer_event_flags, supply_low, reg_wr, reg_rd} = '0;
		{reg_addr, reg_wdata, cf_load_val} = '0;
		alu = '0;
		err_count = 0;
		check_count = 0;
		tick(8);
		t_reset();
		t_alu();
		t_irq();
		t_low();
		finish_test();
	end

	// Cuts a hang short; the tests need about 140 cycles
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		finish_test();
	end
endmodule : cfl_flags_irq_tb_top

/* tb/cfl_supply_model.sv */
// Behavioural low-supply comparator at the detector input
`timescale 1ns/1ps
module cfl_supply_model #(
	parameter int SU_STEPS = 12
) (
	// Supply condition and power control
	input wire logic supply_low,
	input wire logic detector_on,
	input wire logic halt_mode,
	// Comparator output, unrelated to the clock
	output logic     detector_out
);
	int steps;

	// Steps of 1.3 ns from a 0.05 ns offset never land on a clock edge
	initial begin
		detector_out = 1'b1;
		steps = 0;
		#0.05;
		forever begin
			#1.3;
			if (!detector_on || halt_mode) begin
				detector_out = 1'b1; // Unpowered output is junk: drive the harmful level
				steps = 0;
			end else if (steps < SU_STEPS) begin
				detector_out = ~detector_out; // Undefined while starting
				steps++;
			end else begin
				detector_out = supply_low;
			end
		end
	end
endmodule : cfl_supply_model
